// ### src/amv_codec_nodes.v
/*
 * Verb handler for the second input converter node and the mono output pin
 * node: decodes Get and Set verbs from the link, holds the node settings,
 * builds 32-bit responses and drives the settings to the analog blocks.
 * Assumes a controller that sends one command per frame and a bit clock
 * well below the 125 MHz system clock.
 */
// Notes on behaviour
// - Format Get returns word; Set answers zero.
// - Format bit 14 picks 48 or 44.1 kHz.
// - Bits 13:11 multiplier x1, x2, x4; rest reserved.
// - Bits 10:8 divisor is field plus one.
// - Bits 6:4 width 8/16/20/24; rest reserved.
// - Bits 3:0 channel count minus one, resets two.
// - Format bit 15 reads zero, writes ignored.
// - Converter capability word reports fixed features.
// - One short connection entry per node.
// - Processing bit 7 disables offset calculation.
// - Processing bits 1:0 zero bypass high-pass filter.
// - Power set 11 is down; actual reported.
// - Stream and lowest channel held; zero unused.
// - Mono mute and gain, BA0 read, 3A0 write.
// - Output amplifier capability word fixed.
// - Mono pin capability word fixed.
// - Mono pin capabilities output only.
// - Pin control bit 6 enables output path.
// - Pin configuration word resets to fixed fields.
`timescale 1ns/1ns
`include "amv_regs.vh"

module amv_codec_nodes #(
  parameter [3:0] CODEC_ADDR = 4'h0
) (
  // Clock and reset
  input wire i_clk,
  input wire i_rstn,
  // Link pins
  input wire i_bit_clk,
  input wire i_frame_sync,
  input wire i_cmd_data,
  input wire i_link_rstn,
  output wire o_rsp_data,
  // Converter settings
  output reg o_base_44k1,
  output reg [2:0] o_rate_mult,
  output reg [3:0] o_rate_div,
  output reg [4:0] o_sample_bits,
  output reg [4:0] o_channels,
  output reg o_format_reserved,
  output reg o_hpf_enable,
  output reg o_offset_calc_disable,
  output reg o_conv_powered,
  output reg [3:0] o_stream_id,
  output reg [3:0] o_low_channel,
  output reg o_stream_active,
  // Mono output pin settings
  output reg o_mono_mute,
  output reg [4:0] o_mono_gain,
  output reg o_output_path_enable,
  output reg [31:0] o_pin_configuration
);

  //////////////////////////////////////////////////////////////////////////
  // Link reset synchroniser and serial port.
  reg [1:0] lrst_sync_r;
  wire link_clear = ~lrst_sync_r[1];

  always @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      lrst_sync_r <= 2'b00;
    end else begin
      lrst_sync_r <= {lrst_sync_r[0], i_link_rstn};
    end
  end

  wire cmd_valid;
  wire [39:0] cmd_word;
  reg rsp_load_r;
  reg [31:0] rsp_r;

  amv_link_port u_link (
    .i_clk(i_clk),
    .i_rstn(i_rstn),
    .i_clear(link_clear),
    .i_bit_clk(i_bit_clk),
    .i_frame_sync(i_frame_sync),
    .i_cmd_data(i_cmd_data),
    .o_rsp_data(o_rsp_data),
    .i_rsp_load(rsp_load_r),
    .i_rsp_word(rsp_r),
    .o_cmd_valid(cmd_valid),
    .o_cmd_word(cmd_word)
  );

  //////////////////////////////////////////////////////////////////////////
  // Command fields. The top byte of the frame is reserved and ignored.
  wire [3:0] cmd_cad = cmd_word[31:28];
  wire [7:0] cmd_nid = cmd_word[27:20];
  wire [3:0] verb4 = cmd_word[19:16];
  wire [15:0] payload16 = cmd_word[15:0];
  wire [11:0] verb12 = cmd_word[19:8];
  wire [7:0] payload8 = cmd_word[7:0];

  wire for_us = cmd_valid && !link_clear && (cmd_cad == CODEC_ADDR);
  wire is_conv = for_us && (cmd_nid == `AMV_NID_CONV);
  wire is_mono = for_us && (cmd_nid == `AMV_NID_MONO);
  // Format verbs use a four-bit code; they shadow any twelve-bit verb
  // that happens to start with the same nibble.
  wire is_fmt_verb = (verb4 == `AMV_VERB4_GET_FMT) || (verb4 == `AMV_VERB4_SET_FMT);

  function verb_hit;
    input [11:0] verb;
    input [11:0] want;
    input is_fmt;
    begin
      verb_hit = !is_fmt && (verb == want);
    end
  endfunction

  //////////////////////////////////////////////////////////////////////////
  // Node state.
  reg [14:0] fmt_r;
  reg [7:0] proc_r;
  reg [1:0] pwr_set_r;
  reg [3:0] pwr_act_r;
  reg [7:0] strm_r;
  reg vol_mute_r;
  reg [4:0] vol_gain_r;
  reg path_en_r;
  reg [31:0] pincfg_r;

  wire wr_fmt = is_conv && (verb4 == `AMV_VERB4_SET_FMT);
  wire wr_proc = is_conv && verb_hit(verb12, `AMV_VERB_SET_PROC, is_fmt_verb);
  wire wr_pwr = is_conv && verb_hit(verb12, `AMV_VERB_SET_PWR, is_fmt_verb);
  wire wr_strm = is_conv && verb_hit(verb12, `AMV_VERB_SET_STRM, is_fmt_verb);
  wire wr_vol = is_mono && verb_hit(verb12, `AMV_VERB_SET_VOL, is_fmt_verb);
  wire wr_path = is_mono && verb_hit(verb12, `AMV_VERB_SET_PIN_CTRL, is_fmt_verb);
  wire wr_cfg = is_mono && !is_fmt_verb && (verb12[11:2] == `AMV_VERB_SET_CFG_TOP);

  // Each configuration Set verb owns one byte lane, low byte first.
  wire [31:0] pincfg_nxt;
  genvar b;
  generate
    for (b = 0; b < 4; b = b + 1) begin : g_cfg_byte
      assign pincfg_nxt[8*b+7:8*b] = (wr_cfg && (verb12[1:0] == b)) ? payload8 :
                                     pincfg_r[8*b+7:8*b];
    end
  endgenerate

  // Link reset returns every setting to its default, like power-on reset.
  always @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      fmt_r <= `AMV_FMT_RST;
      proc_r <= `AMV_PROC_RST;
      pwr_set_r <= `AMV_PWR_SET_RST;
      pwr_act_r <= `AMV_PWR_ACT_RST;
      strm_r <= `AMV_STRM_RST;
      vol_mute_r <= `AMV_VOL_MUTE_RST;
      vol_gain_r <= `AMV_VOL_GAIN_RST;
      path_en_r <= `AMV_PIN_PATH_RST;
      pincfg_r <= `AMV_CFG_RST;
    end else if (link_clear) begin
      fmt_r <= `AMV_FMT_RST;
      proc_r <= `AMV_PROC_RST;
      pwr_set_r <= `AMV_PWR_SET_RST;
      pwr_act_r <= `AMV_PWR_ACT_RST;
      strm_r <= `AMV_STRM_RST;
      vol_mute_r <= `AMV_VOL_MUTE_RST;
      vol_gain_r <= `AMV_VOL_GAIN_RST;
      path_en_r <= `AMV_PIN_PATH_RST;
      pincfg_r <= `AMV_CFG_RST;
    end else begin
      if (wr_fmt) begin
        // Stream kind bit and bit 7 are dropped here.
        fmt_r <= payload16[14:0] & `AMV_FMT_WR_MASK;
      end
      if (wr_proc) begin
        proc_r <= payload8 & `AMV_PROC_WR_MASK;
      end
      if (wr_pwr) begin
        pwr_set_r <= payload8[1:0];
      end
      // The actual state follows the request one cycle later; there is no
      // slow power sequencing in this block to report a lagging state.
      pwr_act_r <= {2'b00, pwr_set_r};
      if (wr_strm) begin
        strm_r <= payload8;
      end
      if (wr_vol) begin
        vol_mute_r <= payload8[`AMV_VOL_MUTE_BIT];
        vol_gain_r <= payload8[4:0];
      end
      if (wr_path) begin
        path_en_r <= payload8[`AMV_PIN_PATH_BIT];
      end
      pincfg_r <= pincfg_nxt;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Response word. Sets and unknown verbs answer zero.
  reg [31:0] rsp_nxt;

  always @* begin
    rsp_nxt = 32'h0;
    if (is_conv) begin
      if (verb4 == `AMV_VERB4_GET_FMT) begin
        rsp_nxt = {16'h0, 1'b0, fmt_r};
      end else if (verb_hit(verb12, `AMV_VERB_GET_PARAM, is_fmt_verb)) begin
        case (payload8)
          `AMV_PARAM_CAPS: begin
            rsp_nxt = `AMV_CONV_CAPS;
          end
          `AMV_PARAM_LISTLEN: begin
            rsp_nxt = `AMV_CONN_LEN;
          end
          default: begin
            rsp_nxt = 32'h0;
          end
        endcase
      end else if (verb_hit(verb12, `AMV_VERB_GET_CONN, is_fmt_verb)) begin
        rsp_nxt = `AMV_CONV_CONN;
      end else if (verb_hit(verb12, `AMV_VERB_GET_PROC, is_fmt_verb)) begin
        rsp_nxt = {24'h0, proc_r};
      end else if (verb_hit(verb12, `AMV_VERB_GET_PWR, is_fmt_verb)) begin
        rsp_nxt = {24'h0, pwr_act_r, 2'b00, pwr_set_r};
      end else if (verb_hit(verb12, `AMV_VERB_GET_STRM, is_fmt_verb)) begin
        rsp_nxt = {24'h0, strm_r};
      end
    end else if (is_mono) begin
      if (verb_hit(verb12, `AMV_VERB_GET_PARAM, is_fmt_verb)) begin
        case (payload8)
          `AMV_PARAM_CAPS: begin
            rsp_nxt = `AMV_MONO_CAPS;
          end
          `AMV_PARAM_PIN_CAPS: begin
            rsp_nxt = `AMV_MONO_PIN_CAPS;
          end
          `AMV_PARAM_OUTAMP: begin
            rsp_nxt = `AMV_MONO_OUTAMP;
          end
          `AMV_PARAM_LISTLEN: begin
            rsp_nxt = `AMV_CONN_LEN;
          end
          default: begin
            rsp_nxt = 32'h0;
          end
        endcase
      end else if (verb_hit(verb12, `AMV_VERB_GET_CONN, is_fmt_verb)) begin
        rsp_nxt = `AMV_MONO_CONN;
      end else if (verb_hit(verb12, `AMV_VERB_GET_VOL, is_fmt_verb)) begin
        rsp_nxt = {24'h0, vol_mute_r, 2'b00, vol_gain_r};
      end else if (verb_hit(verb12, `AMV_VERB_GET_PIN_CTRL, is_fmt_verb)) begin
        rsp_nxt = {25'h0, path_en_r, 6'h00};
      end else if (verb_hit(verb12, `AMV_VERB_GET_CFG, is_fmt_verb)) begin
        rsp_nxt = pincfg_r;
      end
    end
  end

  // Every addressed command to either node gets exactly one response;
  // commands for other nodes or codecs leave the response line idle.
  always @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      rsp_load_r <= 1'b0;
      rsp_r <= 32'h0;
    end else begin
      rsp_load_r <= is_conv || is_mono;
      if (is_conv || is_mono) begin
        rsp_r <= rsp_nxt;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Decoded settings for the analog blocks, one cycle behind the state.
  wire [2:0] mult_code = fmt_r[13:11];
  wire [2:0] width_code = fmt_r[6:4];
  reg [2:0] mult_nxt;
  reg [4:0] width_nxt;
  reg mult_bad;
  reg width_bad;

  always @* begin
    mult_nxt = 3'd1;
    mult_bad = 1'b0;
    case (mult_code)
      3'b000: begin
        mult_nxt = 3'd1;
      end
      3'b001: begin
        mult_nxt = 3'd2;
      end
      3'b011: begin
        mult_nxt = 3'd4;
      end
      default: begin
        // Reserved codes fall back to x1 and raise the reserved flag.
        mult_nxt = 3'd1;
        mult_bad = 1'b1;
      end
    endcase
    width_nxt = 5'd24;
    width_bad = 1'b0;
    case (width_code)
      3'b000: begin
        width_nxt = 5'd8;
      end
      3'b001: begin
        width_nxt = 5'd16;
      end
      3'b010: begin
        width_nxt = 5'd20;
      end
      3'b011: begin
        width_nxt = 5'd24;
      end
      default: begin
        width_nxt = 5'd24;
        width_bad = 1'b1;
      end
    endcase
  end

  always @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_base_44k1 <= 1'b0;
      o_rate_mult <= 3'd1;
      o_rate_div <= 4'd1;
      o_sample_bits <= 5'd24;
      o_channels <= 5'd2;
      o_format_reserved <= 1'b0;
      o_hpf_enable <= 1'b1;
      o_offset_calc_disable <= 1'b0;
      o_conv_powered <= 1'b0;
      o_stream_id <= 4'h0;
      o_low_channel <= 4'h0;
      o_stream_active <= 1'b0;
      o_mono_mute <= 1'b1;
      o_mono_gain <= `AMV_VOL_GAIN_RST;
      o_output_path_enable <= 1'b0;
      o_pin_configuration <= `AMV_CFG_RST;
    end else begin
      o_base_44k1 <= fmt_r[`AMV_FMT_BASE_BIT];
      o_rate_mult <= mult_nxt;
      o_rate_div <= {1'b0, fmt_r[10:8]} + 4'd1;
      o_sample_bits <= width_nxt;
      o_channels <= {1'b0, fmt_r[3:0]} + 5'd1;
      o_format_reserved <= mult_bad | width_bad;
      o_hpf_enable <= (proc_r[1:0] != 2'b00);
      o_offset_calc_disable <= proc_r[`AMV_PROC_OCDIS_BIT];
      o_conv_powered <= (pwr_set_r != `AMV_PWR_DOWN);
      o_stream_id <= strm_r[7:4];
      o_low_channel <= strm_r[3:0];
      o_stream_active <= (strm_r[7:4] != 4'h0);
      o_mono_mute <= vol_mute_r;
      o_mono_gain <= vol_gain_r;
      o_output_path_enable <= path_en_r;
      o_pin_configuration <= pincfg_r;
    end
  end

endmodule

// ### src/amv_regs.vh
/*
 * Constants for the converter and mono output pin verb handler: node ids,
 * verb codes, parameter ids, capability words, field positions and resets.
 * Assumes it is included by bare name from the design files under src/.
 */
`ifndef AMV_REGS_VH
`define AMV_REGS_VH

// Node ids served by this block.
`define AMV_NID_CONV 8'h13
`define AMV_NID_MONO 8'h14

// Command and response frame layout on the link.
`define AMV_CMD_BITS 6'd40
`define AMV_RSP_BITS 6'd33

// Four-bit verbs carrying a 16-bit payload.
`define AMV_VERB4_GET_FMT 4'ha
`define AMV_VERB4_SET_FMT 4'h2

// Twelve-bit verbs carrying an 8-bit payload.
`define AMV_VERB_GET_PARAM 12'hf00
`define AMV_VERB_GET_CONN 12'hf02
`define AMV_VERB_GET_PROC 12'hf03
`define AMV_VERB_SET_PROC 12'h703
`define AMV_VERB_GET_PWR 12'hf05
`define AMV_VERB_SET_PWR 12'h705
`define AMV_VERB_GET_STRM 12'hf06
`define AMV_VERB_SET_STRM 12'h706
`define AMV_VERB_GET_PIN_CTRL 12'hf07
`define AMV_VERB_SET_PIN_CTRL 12'h707
`define AMV_VERB_GET_CFG 12'hf1c
`define AMV_VERB_SET_CFG_TOP 10'h1c7
`define AMV_VERB_GET_VOL 12'hba0
`define AMV_VERB_SET_VOL 12'h3a0

// Parameter ids of the parameter Get verb.
`define AMV_PARAM_CAPS 8'h09
`define AMV_PARAM_PIN_CAPS 8'h0c
`define AMV_PARAM_LISTLEN 8'h0e
`define AMV_PARAM_OUTAMP 8'h12

// Read-only words.
`define AMV_CONV_CAPS 32'h001d0541
`define AMV_MONO_CAPS 32'h0040010c
`define AMV_MONO_PIN_CAPS 32'h00000010
`define AMV_MONO_OUTAMP 32'h80051f1f
`define AMV_CONN_LEN 32'h00000001
`define AMV_CONV_CONN 32'h0000001e
`define AMV_MONO_CONN 32'h00000015

// Field positions and writable masks.
`define AMV_FMT_BASE_BIT 14
`define AMV_FMT_WR_MASK 15'h7f7f
`define AMV_PROC_OCDIS_BIT 7
`define AMV_PROC_WR_MASK 8'h83
`define AMV_VOL_MUTE_BIT 7
`define AMV_PIN_PATH_BIT 6
`define AMV_PWR_DOWN 2'b11

// Reset values.
`define AMV_FMT_RST 15'h0031
`define AMV_PROC_RST 8'h01
`define AMV_PWR_SET_RST 2'h3
`define AMV_PWR_ACT_RST 4'h3
`define AMV_STRM_RST 8'h00
`define AMV_VOL_MUTE_RST 1'b1
`define AMV_VOL_GAIN_RST 5'h1f
`define AMV_PIN_PATH_RST 1'b0
`define AMV_CFG_RST 32'h500700f0

`endif

// ### src/amv_link_port.v
/*
 * Serial side of the verb handler: samples the link bit clock, frame sync
 * and command data with the system clock, assembles 40-bit commands and
 * shifts a flagged 32-bit response out. Assumes the bit clock is much slower
 * than i_clk so that every bit clock level lasts several system cycles.
 */
`timescale 1ns/1ns
`include "amv_regs.vh"

module amv_link_port (
  // Clock and reset
  input wire i_clk,
  input wire i_rstn,
  input wire i_clear,
  // Link pins
  input wire i_bit_clk,
  input wire i_frame_sync,
  input wire i_cmd_data,
  output reg o_rsp_data,
  // Decoder side
  input wire i_rsp_load,
  input wire [31:0] i_rsp_word,
  output reg o_cmd_valid,
  output reg [39:0] o_cmd_word
);

  reg [2:0] meta_r;
  reg [2:0] sync_r;
  reg bclk_prev_r;
  reg [5:0] bit_cnt_r;
  reg [38:0] shift_r;
  reg [32:0] rsp_sh_r;
  reg [5:0] rsp_left_r;

  wire bclk_s = sync_r[2];
  wire fsync_s = sync_r[1];
  wire sdo_s = sync_r[0];
  wire bclk_rise = bclk_s & ~bclk_prev_r;
  wire bclk_fall = ~bclk_s & bclk_prev_r;

  //////////////////////////////////////////////////////////////////////////
  // Two-stage synchronisers; edges are found on the second stage only.
  always @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      meta_r <= 3'h0;
      sync_r <= 3'h0;
      bclk_prev_r <= 1'b0;
    end else begin
      meta_r <= {i_bit_clk, i_frame_sync, i_cmd_data};
      sync_r <= meta_r;
      bclk_prev_r <= sync_r[2];
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Command assembly, MSB first, sampled on bit clock rising edges.
  always @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      bit_cnt_r <= 6'd0;
      shift_r <= 39'h0;
      o_cmd_valid <= 1'b0;
      o_cmd_word <= 40'h0;
    end else begin
      o_cmd_valid <= 1'b0;
      if (i_clear) begin
        bit_cnt_r <= 6'd0;
      end else if (bclk_rise) begin
        if (fsync_s) begin
          shift_r <= {38'h0, sdo_s};
          bit_cnt_r <= 6'd1;
        end else if (bit_cnt_r != 6'd0) begin
          shift_r <= {shift_r[37:0], sdo_s};
          if (bit_cnt_r == `AMV_CMD_BITS - 6'd1) begin
            o_cmd_valid <= 1'b1;
            o_cmd_word <= {shift_r, sdo_s};
            bit_cnt_r <= 6'd0;
          end else begin
            bit_cnt_r <= bit_cnt_r + 6'd1;
          end
        end
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Response: a leading valid bit, then 32 bits, changed on falling edges
  // so the controller can sample on the next rising edge.
  always @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      rsp_sh_r <= 33'h0;
      rsp_left_r <= 6'd0;
      o_rsp_data <= 1'b0;
    end else if (i_clear) begin
      rsp_left_r <= 6'd0;
      o_rsp_data <= 1'b0;
    end else if (i_rsp_load) begin
      rsp_sh_r <= {1'b1, i_rsp_word};
      rsp_left_r <= `AMV_RSP_BITS;
    end else if (bclk_fall) begin
      if (rsp_left_r != 6'd0) begin
        o_rsp_data <= rsp_sh_r[32];
        rsp_sh_r <= {rsp_sh_r[31:0], 1'b0};
        rsp_left_r <= rsp_left_r - 6'd1;
      end else begin
        o_rsp_data <= 1'b0;
      end
    end
  end

endmodule

// ### verif/amv_codec_nodes_props.sv
/* Checker for the verb handler: relations among its setting outputs and
   the response pin. Sees only the ports of amv_codec_nodes via bind. */
`timescale 1ns/1ns
module amv_codec_nodes_props (
  // Clock, reset and link
  input wire i_clk,
  input wire i_rstn,
  input wire i_bit_clk,
  input wire i_link_rstn,
  input wire o_rsp_data,
  // Settings
  input wire [2:0] o_rate_mult,
  input wire [3:0] o_rate_div,
  input wire [4:0] o_sample_bits,
  input wire [4:0] o_channels,
  input wire o_format_reserved,
  input wire [3:0] o_stream_id,
  input wire o_stream_active,
  input wire o_mono_mute,
  input wire [4:0] o_mono_gain,
  input wire o_output_path_enable,
  input wire [31:0] o_pin_configuration
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rstn);
  a_stream_in_use: assert property (o_stream_active == (o_stream_id != 4'h0))
    else $error("stream active flag disagrees with stream id");
  a_mult_legal: assert property (o_rate_mult inside {3'h1, 3'h2, 3'h4})
    else $error("rate multiplier outside x1 x2 x4");
  a_div_range: assert property (o_rate_div != 4'h0 && o_rate_div <= 4'h8)
    else $error("rate divisor outside 1 to 8");
  a_width_legal: assert property (o_sample_bits inside {5'h08, 5'h10, 5'h14, 5'h18})
    else $error("sample width not 8 16 20 24");
  a_chan_range: assert property (o_channels != 5'h00 && o_channels <= 5'h10)
    else $error("channel count outside 1 to 16");
  a_resv_fallback: assert property (o_format_reserved |-> o_rate_mult == 3'h1 || o_sample_bits == 5'h18)
    else $error("reserved format code without fallback");
  a_reset_defaults: assert property ($rose(i_rstn) |-> o_mono_mute && o_mono_gain == 5'h1f
    && o_pin_configuration == 32'h500700f0 && !o_output_path_enable)
    else $error("mono settings not at defaults after reset");
  a_link_rst_dflt: assert property (!i_link_rstn [*6] |-> o_mono_mute && o_stream_id == 4'h0
    && o_rate_div == 4'h1 && !o_output_path_enable && !o_rsp_data)
    else $error("settings not restored during link reset");
  a_rsp_idle_quiet: assert property ($stable(i_bit_clk) [*8] |=> $stable(o_rsp_data))
    else $error("response pin moved while bit clock stood still");
  c_stream: cover property (o_stream_active);
  c_resv: cover property (o_format_reserved);
  c_path: cover property (o_output_path_enable && !o_mono_mute);
  c_rsp: cover property ($rose(o_rsp_data));
endmodule

bind amv_codec_nodes amv_codec_nodes_props i_props (
  .i_clk(i_clk), .i_rstn(i_rstn), .i_bit_clk(i_bit_clk), .i_link_rstn(i_link_rstn),
  .o_rsp_data(o_rsp_data), .o_rate_mult(o_rate_mult), .o_rate_div(o_rate_div),
  .o_sample_bits(o_sample_bits), .o_channels(o_channels),
  .o_format_reserved(o_format_reserved), .o_stream_id(o_stream_id),
  .o_stream_active(o_stream_active), .o_mono_mute(o_mono_mute), .o_mono_gain(o_mono_gain),
  .o_output_path_enable(o_output_path_enable), .o_pin_configuration(o_pin_configuration)
);

// ### verif/amv_link_host.sv
/* Link controller model: shifts a 40-bit command out under frame sync and
   captures the flagged response. Assumes the device answers within the
   tail of bit clocks that follows each command. */
`timescale 1ns/1ns
module amv_link_host (
  // Link pins
  output reg o_bit_clk,
  output reg o_frame_sync,
  output reg o_cmd_data,
  input wire i_rsp_data
);
  initial begin
    o_bit_clk = 1'b0;
    o_frame_sync = 1'b0;
    o_cmd_data = 1'b0;
  end
  // Pin edges are kept off the system clock's rising edge.
  task half(input integer d);
    begin
      #d;
      if ($time % 8 == 4) #1;
    end
  endtask
  // The bit clock runs only for a command and its response tail.
  task run(input [39:0] cmd, output [31:0] rsp, output got);
    integer k;
    integer n;
    begin
      rsp = 32'h0;
      got = 1'b0;
      n = 0;
      for (k = 0; k < 76; k = k + 1) begin
        o_bit_clk = 1'b0;
        o_frame_sync = (k == 0);
        o_cmd_data = (k < 40) ? cmd[39 - k] : ~o_cmd_data;
        half(62);
        o_bit_clk = 1'b1;
        if (got && n < 32) begin
          rsp = {rsp[30:0], i_rsp_data};
          n = n + 1;
        end else if (k >= 40 && !got && i_rsp_data)
          got = 1'b1;
        half(63);
      end
      o_bit_clk = 1'b0;
      o_cmd_data = ~o_cmd_data;
    end
  endtask
endmodule

// ### verif/amv_codec_nodes_tb.sv
/* Self-checking bench for the verb handler: the controller model sends
   Get and Set verbs; responses and setting outputs are compared. Assumes
   the checker is bound from its own file. */
`timescale 1ns/1ns
module amv_codec_nodes_tb;
  localparam [3:0] ADDR = 4'h5;
  reg i_clk;
  reg i_rstn;
  reg i_link_rstn;
  wire bclk, fsync, cdata, rsp_pin, base, resv, hpf, ocd, pwr, sact, mute, path_on;
  wire [2:0] mult;
  wire [3:0] div, sid, lch;
  wire [4:0] bits, chan, gain;
  wire [31:0] cfg;
  wire [31:0] fmt_o = {13'h0, base, mult, div, bits, chan, resv};
  wire [31:0] misc_o = {13'h0, hpf, ocd, pwr, sact, mute, path_on, sid, lch, gain};
  integer n_fail;
  integer cmp_count;
  integer cyc;
  reg [31:0] rsp;
  reg got;
  reg [3:0] m;
  reg [2:0] em;
  reg [4:0] eb;

  amv_codec_nodes #(.CODEC_ADDR(ADDR)) i_amv_codec_nodes (
    .i_clk(i_clk), .i_rstn(i_rstn), .i_bit_clk(bclk), .i_frame_sync(fsync),
    .i_cmd_data(cdata), .i_link_rstn(i_link_rstn), .o_rsp_data(rsp_pin),
    .o_base_44k1(base), .o_rate_mult(mult), .o_rate_div(div), .o_sample_bits(bits),
    .o_channels(chan), .o_format_reserved(resv), .o_hpf_enable(hpf),
    .o_offset_calc_disable(ocd), .o_conv_powered(pwr), .o_stream_id(sid),
    .o_low_channel(lch), .o_stream_active(sact), .o_mono_mute(mute), .o_mono_gain(gain),
    .o_output_path_enable(path_on), .o_pin_configuration(cfg));
  amv_link_host i_amv_link_host (
    .o_bit_clk(bclk), .o_frame_sync(fsync), .o_cmd_data(cdata), .i_rsp_data(rsp_pin));

  initial begin
    i_clk = 1'b0;
    forever #4 i_clk = ~i_clk;
  end
  always @(posedge i_clk) begin
    cyc = cyc + 1;
    if (cyc == 85000) begin
      n_fail = n_fail + 1;
      end_of_test;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  task end_of_test;
    begin
      $display("compares %0d mismatches %0d", cmp_count, n_fail);
      if (n_fail == 0 && cmp_count > 0)
        $display("DONE - PASS");
      else
        $display("DONE - FAIL");
      $finish;
    end
  endtask
  task chk(input string nm, input [31:0] e, input [31:0] s);
    begin
      cmp_count = cmp_count + 1;
      if (s !== e) begin
        n_fail = n_fail + 1;
        $display("MISMATCH %s expected %h seen %h", nm, e, s);
      end
    end
  endtask
  task get(input [7:0] nid, input [19:0] verb, input [31:0] e, input string nm);
    begin
      i_amv_link_host.run({8'h00, ADDR, nid, verb}, rsp, got);
      chk("valid bit", 32'h1, {31'h0, got});
      chk(nm, e, rsp);
    end
  endtask
  task set(input [7:0] nid, input [19:0] verb);
    begin
      get(nid, verb, 32'h0, "set response");
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task t_reset;
    begin
      chk("fmt outs", {13'h0, 1'b0, 3'h1, 4'h1, 5'h18, 5'h02, 1'b0}, fmt_o);
      chk("misc outs", {13'h0, 6'b100010, 8'h00, 5'h1f}, misc_o);
      get(8'h13, 20'ha0000, 32'h00000031, "format");
      get(8'h13, 20'hf0300, 32'h00000001, "proc");
      get(8'h13, 20'hf0500, 32'h00000033, "power");
      get(8'h13, 20'hf0600, 32'h00000000, "stream");
      get(8'h14, 20'hba000, 32'h0000009f, "volume");
      get(8'h14, 20'hf0700, 32'h00000000, "pin ctrl");
      get(8'h14, 20'hf1c00, 32'h500700f0, "config");
    end
  endtask
  task t_params;
    begin
      get(8'h13, 20'hf0009, 32'h001d0541, "conv caps");
      get(8'h14, 20'hf0009, 32'h0040010c, "mono caps");
      get(8'h14, 20'hf000c, 32'h00000010, "pin caps");
      get(8'h14, 20'hf0012, 32'h80051f1f, "amp caps");
      get(8'h13, 20'hf000e, 32'h00000001, "conv len");
      get(8'h14, 20'hf000e, 32'h00000001, "mono len");
      get(8'h13, 20'hf0200, 32'h0000001e, "conv list");
      get(8'h14, 20'hf0200, 32'h00000015, "mono list");
    end
  endtask
  task t_format;
    begin
      set(8'h13, 20'h2c0d5);
      get(8'h13, 20'ha0000, 32'h00004055, "fmt rd");
      chk("fmt outs", {13'h0, 1'b1, 3'h1, 4'h1, 5'h18, 5'h06, 1'b1}, fmt_o);
      for (m = 4'h0; m < 4'h8; m = m + 4'h1) begin
        set(8'h13, {4'h2, 2'b00, m[2:0], m[2:0], 1'b0, m[2:0], 1'b1, m[2:0]});
        em = (m == 4'h1) ? 3'h2 : (m == 4'h3) ? 3'h4 : 3'h1;
        eb = (m == 4'h0) ? 5'h08 : (m == 4'h1) ? 5'h10 : (m == 4'h2) ? 5'h14 : 5'h18;
        chk("fmt loop", {13'h0, 1'b0, em, m + 4'h1, eb, 5'h09 + {2'b0, m[2:0]},
          (m == 4'h2 || m > 4'h3)}, fmt_o);
      end
    end
  endtask
  task t_proc;
    begin
      set(8'h13, 20'h703ff);
      get(8'h13, 20'hf0300, 32'h00000083, "proc rd");
      chk("filter on", 32'h3, {30'h0, hpf, ocd});
      set(8'h13, 20'h70380);
      chk("filter off", 32'h1, {30'h0, hpf, ocd});
      set(8'h13, 20'h70502);
      get(8'h13, 20'hf0500, 32'h00000022, "power rd");
      chk("powered", 32'h1, {31'h0, pwr});
      set(8'h13, 20'h70503);
      chk("powered down", 32'h0, {31'h0, pwr});
      set(8'h13, 20'h7065a);
      get(8'h13, 20'hf0600, 32'h0000005a, "stream rd");
      chk("stream outs", 32'hb5, {23'h0, sid, lch, sact});
      set(8'h13, 20'h70600);
      chk("stream unused", 32'h0, {31'h0, sact});
    end
  endtask
  task t_mono;
    begin
      set(8'h14, 20'h3a065);
      get(8'h14, 20'hba000, 32'h00000005, "vol rd");
      chk("vol outs", 32'h05, {26'h0, mute, gain});
      set(8'h14, 20'h707ff);
      get(8'h14, 20'hf0700, 32'h00000040, "pin ctrl rd");
      chk("path en", 32'h1, {31'h0, path_on});
      // The low byte keeps a nonzero association.
      set(8'h14, 20'h71c12);
      set(8'h14, 20'h71d34);
      set(8'h14, 20'h71e56);
      set(8'h14, 20'h71f78);
      get(8'h14, 20'hf1c00, 32'h78563412, "cfg rd");
      chk("cfg out", 32'h78563412, cfg);
    end
  endtask
  task t_refuse;
    begin
      i_amv_link_host.run({8'h00, 4'h3, 8'h14, 20'h3a09f}, rsp, got);
      chk("other addr", 32'h0, {31'h0, got});
      i_amv_link_host.run({8'h00, ADDR, 8'h15, 20'h3a09f}, rsp, got);
      chk("other node", 32'h0, {31'h0, got});
      chk("vol kept", 32'h05, {26'h0, mute, gain});
      get(8'h13, 20'hf0f00, 32'h0, "unknown verb");
      get(8'h14, 20'hf0033, 32'h0, "unknown param");
      @(negedge i_clk);
      i_link_rstn = 1'b0;
      repeat (10) @(negedge i_clk);
      i_link_rstn = 1'b1;
      repeat (8) @(negedge i_clk);
      chk("misc lrst", {13'h0, 6'b100010, 8'h00, 5'h1f}, misc_o);
      get(8'h14, 20'hf1c00, 32'h500700f0, "cfg lrst");
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    n_fail = 0;
    cmp_count = 0;
    cyc = 0;
    i_rstn = 1'b0;
    i_link_rstn = 1'b0;
    repeat (16) @(negedge i_clk);
    i_rstn = 1'b1;
    i_link_rstn = 1'b1;
    repeat (8) @(negedge i_clk);
    t_reset;
    t_params;
    t_format;
    t_proc;
    t_mono;
    t_refuse;
    end_of_test;
  end
endmodule
